// File: bench/prs_mgmt_model.sv
// management station stand-in that writes the software reset bit
module prs_mgmt_model (
  // clock
  input wire logic clk_sys,
  // bench request and sequencer readiness
  input wire logic reset_req,
  input wire logic mgmt_ready,
  // write strobe of the software reset bit
  output logic     sw_reset_write = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle write
  // the port is written only while it answers; a request made while it does not is dropped, not held
  always @(posedge clk_sys)
    sw_reset_write <= reset_req && mgmt_ready && !sw_reset_write;
endmodule // prs_mgmt_model

// File: bench/prs_seq_asserts.sv
// port-level assertions for the reset and power-down sequencer
module prs_seq_asserts #(
  parameter logic [prs_pkg::CNT_W-1:0] CLK_VALID_CYC = prs_pkg::CLK_VALID_CYC
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // inputs
  input wire logic       external_reset_low,
  input wire logic       sw_reset_write,
  input wire logic       power_down_ctrl,
  // outputs
  input wire logic       sw_reset_bit,
  input wire logic [4:0] mgmt_address,
  input wire logic       mgmt_ready,
  input wire logic       regs_to_default,
  input wire logic       latch_status_clear,
  input wire logic       core_reset,
  input wire logic       power_down,
  input wire logic       mac_out_enable,
  input wire logic       mac_in_isolate,
  input wire logic       line_transmit_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] low_run_r;
  logic       seen_r;
  // saturating count of sampled pin lows
  always_ff @(posedge clk_sys)
    low_run_r <= (reset || external_reset_low) ? 4'h0 : low_run_r + 4'(low_run_r != 4'hF);
  // power-on reset lasts until the port first answers
  always_ff @(posedge clk_sys)
    seen_r <= !reset && (seen_r || mgmt_ready);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_hw_low_min: assert property (
    $rose(core_reset) && !sw_reset_bit |-> low_run_r >= 4'h5)
    else $error("reset after short pin low");
  a_exit_time: assert property (
    $rose(external_reset_low) && core_reset && seen_r |-> ##[1:16] mgmt_ready)
    else $error("port late after pin release");
  a_sw_two: assert property (
    $rose(sw_reset_bit) ##0 (!sw_reset_write) [*2] |-> sw_reset_bit ##1 !sw_reset_bit)
    else $error("software hold not two cycles");
  a_sw_no_pd: assert property (
    sw_reset_bit && !power_down_ctrl && external_reset_low |-> !power_down)
    else $error("software reset powered down");
  a_sw_default: assert property (
    $fell(sw_reset_bit) |-> regs_to_default)
    else $error("bit cleared without defaults");
  a_sw_addr: assert property (
    $fell(sw_reset_bit) |-> ##6 $rose(mgmt_ready) && mgmt_address == $past(mgmt_address, 6))
    else $error("address changed by software reset");
  a_entry_quiet: assert property (
    $rose(core_reset) |-> latch_status_clear && !mac_out_enable && mac_in_isolate
      && !line_transmit_oe)
    else $error("reset entry incomplete");
  a_pd_latch: assert property (
    $rose(power_down_ctrl) && !core_reset |=> latch_status_clear && power_down
      && !regs_to_default)
    else $error("power-down bit entry wrong");
  a_pd_quiet: assert property (
    power_down [*8] |-> !mac_out_enable && !line_transmit_oe)
    else $error("outputs live in power-down");
endmodule // prs_seq_asserts

bind prs_seq prs_seq_asserts #(.CLK_VALID_CYC(CLK_VALID_CYC)) chk_u (
  .clk_sys, .reset, .external_reset_low, .sw_reset_write, .power_down_ctrl, .sw_reset_bit,
  .mgmt_address, .mgmt_ready, .regs_to_default, .latch_status_clear, .core_reset,
  .power_down, .mac_out_enable, .mac_in_isolate, .line_transmit_oe);

// File: bench/tb.sv
// self-checking bench for the reset and power-down sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       external_reset_low = 1'b1;
  logic       supply_good = 1'b0;
  logic [4:0] address_straps = 5'h0A;
  logic       power_down_ctrl = 1'b0;
  logic       auto_off_100_in_10 = 1'b0;
  logic       auto_off_10_in_100 = 1'b0;
  logic       speed_is_100 = 1'b0;
  logic       reset_req = 1'b0;
  logic       sw_reset_write, sw_reset_bit, mgmt_ready, regs_to_default, latch_status_clear;
  logic       core_reset, power_down, mac_out_enable, mac_in_isolate, line_transmit_oe;
  logic       link_clocks_valid, enable_100_modules, enable_10_modules;
  logic [4:0] mgmt_address;
  int         mismatches = 0;
  int         checked = 0;
  // counts kept four-state so an unknown output poisons the sum
  logic [7:0] n_sw, n_pd, n_lc, n_rd;

  always #50 clk_sys = ~clk_sys;

  // short clocks-valid count keeps the run brief
  prs_seq #(.CLK_VALID_CYC(20'h00032)) dut_u (
    .clk_sys, .reset, .external_reset_low, .supply_good, .address_straps, .sw_reset_write,
    .power_down_ctrl, .auto_off_100_in_10, .auto_off_10_in_100, .speed_is_100, .sw_reset_bit,
    .mgmt_address, .mgmt_ready, .regs_to_default, .latch_status_clear, .core_reset,
    .power_down, .mac_out_enable, .mac_in_isolate, .line_transmit_oe, .link_clocks_valid,
    .enable_100_modules, .enable_10_modules);
  prs_mgmt_model mdl_u (.clk_sys, .reset_req, .mgmt_ready, .sw_reset_write);

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // sampled mid-cycle so edge updates have landed
  task automatic tally(input int n);
    {n_sw, n_pd, n_lc, n_rd} = '0;
    repeat (n)
    begin
      @(negedge clk_sys);
      n_sw = n_sw + 8'(sw_reset_bit);
      n_pd = n_pd + 8'(power_down);
      n_lc = n_lc + 8'(latch_status_clear);
      n_rd = n_rd + 8'(regs_to_default);
    end
  endtask

  task automatic wait_hi(input bit clocks, output int n);
    n = 0;
    while ((clocks ? link_clocks_valid : mgmt_ready) !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
      if (n > 400)
      begin
        mismatches++;
        wrap_up();
      end
    end
  endtask

  task automatic t_por;
    int n;
    @(posedge clk_sys);
    supply_good <= 1'b1;
    cyc(20);
    external_reset_low <= 1'b0;
    cyc(8);
    external_reset_low <= 1'b1;
    wait_hi(1'b0, n);
    chk(8'(n >= 176 && n <= 184), 8'h01);
    chk(8'(mgmt_address), 8'h0A);
    chk(8'({sw_reset_bit, link_clocks_valid}), 8'h00);
    wait_hi(1'b1, n);
    chk(8'(n >= 49 && n <= 51), 8'h01);
  endtask

  task automatic t_speed;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      {auto_off_100_in_10, auto_off_10_in_100, speed_is_100} <= 3'(i);
      cyc(2);
      @(negedge clk_sys);
      chk(8'(enable_100_modules), 8'(!(i[2] && !i[0])));
      chk(8'(enable_10_modules), 8'(!(i[1] && i[0])));
    end
  endtask

  task automatic t_sw;
    @(posedge clk_sys);
    address_straps <= 5'h15;
    reset_req <= 1'b1;
    @(posedge clk_sys);
    reset_req <= 1'b0;
    tally(14);
    chk(8'(n_sw), 8'h02);
    chk(8'(n_pd), 8'h00);
    chk(8'(n_rd), 8'h01);
    chk(8'({sw_reset_bit, mgmt_ready}), 8'h01);
    chk(8'(mgmt_address), 8'h0A);
  endtask

  task automatic t_pd;
    @(posedge clk_sys);
    power_down_ctrl <= 1'b1;
    tally(12);
    chk(8'(n_lc), 8'h01);
    chk(8'(n_rd), 8'h00);
    chk(8'({power_down, mac_out_enable, line_transmit_oe}), 8'h04);
    @(posedge clk_sys);
    power_down_ctrl <= 1'b0;
    cyc(4);
  endtask

  task automatic t_hw;
    int n;
    @(posedge clk_sys);
    external_reset_low <= 1'b0;
    cyc(4);
    external_reset_low <= 1'b1;
    tally(10);
    chk(8'({core_reset, mgmt_ready}), 8'h01);
    @(posedge clk_sys);
    external_reset_low <= 1'b0;
    address_straps <= 5'h03;
    tally(12);
    chk(8'({core_reset, power_down, mac_out_enable, line_transmit_oe, mac_in_isolate}),
        8'h19);
    chk(8'(n_lc), 8'h01);
    @(posedge clk_sys);
    external_reset_low <= 1'b1;
    wait_hi(1'b0, n);
    chk(8'(n <= 16), 8'h01);
    chk({power_down, mac_out_enable, line_transmit_oe, mgmt_address}, 8'h63);
    chk(8'(sw_reset_bit), 8'h00);
  endtask

  initial
  begin
    cyc(12);
    reset <= 1'b0;
    t_por();
    t_speed();
    t_sw();
    t_pd();
    t_hw();
    wrap_up();
  end
endmodule // tb

// File: common/prs_pkg.sv
// constants for the phy reset and power-down sequencer
// Behaviour
// (RULE_01) external reset pin must stay low five clock cycles before reset starts
// (RULE_02) after pin rises, exit steps finish within 640 ns; management port then works; code: port answers up to 900 ns after pin rises
// (RULE_03) reset cycle ends when link clocks valid, about 53 ms; MAC waits for that
// (RULE_04) at power-up, once supply is good, hold reset about 20 us, then exit normally
// (RULE_05) during power-on reset the external reset pin is ignored
// (RULE_06) writing one to software reset bit holds reset for two clock cycles
// (RULE_07) software reset does everything a reset does except entering power-down
// (RULE_08) every reset end restores register defaults and clears software reset bit
// (RULE_09) hardware and power-on resets never set the software reset bit
// (RULE_10) leaving software reset keeps the current management address
// (RULE_11) power-down whenever reset pin is low or power-down bit is one
// (RULE_12) power-down disables functions, drives MAC outputs low, tri-states line transmitter
// (RULE_13) power-down by control bit clears only latching status bits
// (RULE_14) bit 19.0 set disables 100 Mb/s modules while running at 10 Mb/s
// (RULE_15) bit 19.1 set disables 10 Mb/s modules while running at 100 Mb/s
// (RULE_16) entering reset isolates MAC, drives outputs low, tri-states line, powers down
// (RULE_17) leaving hardware or power-on reset captures address from configuration inputs
// (RULE_18) reset pin is synchronised before its low time is counted
package prs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  localparam logic [2:0]  HW_LOW_MIN_CYC = 3'h5;
  localparam int unsigned EXIT_TIME_NS   = 640;
  localparam int unsigned POR_HOLD_US    = 20;
  localparam int unsigned CLK_VALID_MS   = 53;

  localparam int unsigned CNT_W = 20;

  // longest time: round down, never below one cycle
  localparam int unsigned EXIT_CYC_I =
    (EXIT_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (EXIT_TIME_NS / CLK_PERIOD_NS);
  localparam int unsigned POR_HOLD_CYC_I = (POR_HOLD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CLK_VALID_CYC_I = (CLK_VALID_MS * 1000000) / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0] EXIT_CYC      = CNT_W'(EXIT_CYC_I);
  localparam logic [CNT_W-1:0] POR_HOLD_CYC  = CNT_W'(POR_HOLD_CYC_I);
  localparam logic [CNT_W-1:0] CLK_VALID_CYC = CNT_W'(CLK_VALID_CYC_I);
  localparam logic [CNT_W-1:0] SW_HOLD_CYC   = 20'h00002;

  localparam logic [4:0] ADDR_RST = 5'h00;

  typedef enum logic [2:0] {
    PRS_POR_WAIT = 3'h0,
    PRS_POR_HOLD = 3'h1,
    PRS_EXIT     = 3'h3,
    PRS_CLK_WAIT = 3'h2,
    PRS_RUN      = 3'h6,
    PRS_HW_HOLD  = 3'h7,
    PRS_SW_HOLD  = 3'h5
  } prs_state_t;

endpackage

// File: core/prs_seq.sv
// reset, power-down and automatic power-saving sequencer of the phy
module prs_seq #(
  parameter logic [prs_pkg::CNT_W-1:0] CLK_VALID_CYC = prs_pkg::CLK_VALID_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // pins from outside the clock domain
  input  wire logic       external_reset_low,
  input  wire logic       supply_good,
  input  wire logic [4:0] address_straps,
  // management control bits
  input  wire logic       sw_reset_write,
  input  wire logic       power_down_ctrl,
  input  wire logic       auto_off_100_in_10,
  input  wire logic       auto_off_10_in_100,
  // current line speed
  input  wire logic       speed_is_100,
  // management status
  output logic            sw_reset_bit,
  output logic [4:0]      mgmt_address,
  output logic            mgmt_ready,
  output logic            regs_to_default,
  output logic            latch_status_clear,
  // core and interface control
  output logic            core_reset,
  output logic            power_down,
  output logic            mac_out_enable,
  output logic            mac_in_isolate,
  output logic            line_transmit_oe,
  output logic            link_clocks_valid,
  output logic            enable_100_modules,
  output logic            enable_10_modules
);

  typedef struct packed {
    prs_pkg::prs_state_t        state;
    logic [prs_pkg::CNT_W-1:0]  cnt;
    logic [2:0]                 low_cnt;
    logic                       hw_exit;
    logic                       pd_prev;
    logic                       sw_bit;
    logic [4:0]                 addr;
    logic                       mgmt_ready;
    logic                       regs_default;
    logic                       latch_clear;
    logic                       core_reset;
    logic                       power_down;
    logic                       mac_en;
    logic                       mac_iso;
    logic                       line_oe;
    logic                       clocks_valid;
    logic                       en_100;
    logic                       en_10;
  } prs_regs_t;

  prs_regs_t  q_r;
  prs_regs_t  q_nxt;

  logic       pin_low_s;
  logic       supply_s;
  logic [4:0] straps_s;

  // (RULE_18) synchronise pins first
  prs_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    // pin inverted ahead of the stages so their cleared state reads as not low
    .async_in ({~external_reset_low, supply_good, address_straps}),
    .sync_out ({pin_low_s, supply_s, straps_s})
  );

  logic pin_low;
  logic hw_req;
  logic in_por;
  logic sw_ok;
  logic in_reset;
  logic running;

  assign pin_low = pin_low_s;
  // (RULE_01) fifth low cycle starts reset
  assign hw_req  = pin_low && (q_r.low_cnt >= (prs_pkg::HW_LOW_MIN_CYC - 3'h1));
  assign in_por  = (q_r.state == prs_pkg::PRS_POR_WAIT) || (q_r.state == prs_pkg::PRS_POR_HOLD);
  assign sw_ok   = (q_r.state == prs_pkg::PRS_CLK_WAIT) || (q_r.state == prs_pkg::PRS_RUN)
                   || (q_r.state == prs_pkg::PRS_SW_HOLD);

  always_comb
  begin
    q_nxt              = q_r;
    q_nxt.regs_default = 1'b0;
    q_nxt.latch_clear  = 1'b0;
    q_nxt.pd_prev      = power_down_ctrl;
    in_reset           = 1'b0;
    running            = 1'b0;

    // saturating count of consecutive synchronised low cycles
    if (!pin_low)
      q_nxt.low_cnt = 3'h0;
    else if (q_r.low_cnt != prs_pkg::HW_LOW_MIN_CYC)
      q_nxt.low_cnt = q_r.low_cnt + 3'h1;

    unique case (q_r.state)
      prs_pkg::PRS_POR_WAIT:
      begin
        // (RULE_04) supply good starts the hold
        if (supply_s)
        begin
          q_nxt.state       = prs_pkg::PRS_POR_HOLD;
          q_nxt.cnt         = '0;
          q_nxt.latch_clear = 1'b1;
        end
      end
      prs_pkg::PRS_POR_HOLD:
      begin
        q_nxt.cnt = q_r.cnt + 20'h00001;
        // (RULE_04) automatic exit after the hold
        if (q_r.cnt == prs_pkg::POR_HOLD_CYC - 20'h00001)
        begin
          q_nxt.state   = prs_pkg::PRS_EXIT;
          q_nxt.cnt     = '0;
          q_nxt.hw_exit = 1'b1;
        end
      end
      prs_pkg::PRS_HW_HOLD:
      begin
        if (!pin_low)
        begin
          q_nxt.state   = prs_pkg::PRS_EXIT;
          q_nxt.cnt     = '0;
          q_nxt.hw_exit = 1'b1;
        end
      end
      prs_pkg::PRS_SW_HOLD:
      begin
        q_nxt.cnt = q_r.cnt + 20'h00001;
        // (RULE_06) two-cycle reset hold
        if (q_r.cnt == prs_pkg::SW_HOLD_CYC - 20'h00001)
        begin
          q_nxt.state        = prs_pkg::PRS_EXIT;
          q_nxt.cnt          = '0;
          q_nxt.hw_exit      = 1'b0;
          // (RULE_08) defaults restore, bit self-clears
          q_nxt.sw_bit       = 1'b0;
          q_nxt.regs_default = 1'b1;
        end
      end
      prs_pkg::PRS_EXIT:
      begin
        q_nxt.cnt = q_r.cnt + 20'h00001;
        // (RULE_02) exit steps bounded by 640 ns
        if (q_r.cnt == prs_pkg::EXIT_CYC - 20'h00001)
        begin
          q_nxt.state = prs_pkg::PRS_CLK_WAIT;
          q_nxt.cnt   = '0;
          // (RULE_17) capture address on hw exit
          if (q_r.hw_exit)
          begin
            q_nxt.addr         = straps_s;
            q_nxt.regs_default = 1'b1;
          end
          // (RULE_10) sw exit keeps the address
        end
      end
      prs_pkg::PRS_CLK_WAIT:
      begin
        q_nxt.cnt = q_r.cnt + 20'h00001;
        // (RULE_03) cycle ends once clocks valid
        if (q_r.cnt == CLK_VALID_CYC - 20'h00001)
          q_nxt.state = prs_pkg::PRS_RUN;
      end
      prs_pkg::PRS_RUN:
      begin
        q_nxt.cnt = q_r.cnt;
      end
      default:
      begin
        q_nxt.state = prs_pkg::PRS_POR_WAIT;
        q_nxt.cnt   = '0;
      end
    endcase

    // (RULE_05) pin ignored during power-on reset
    if (!in_por && hw_req && (q_r.state != prs_pkg::PRS_HW_HOLD))
    begin
      // (RULE_16) enter reset, clear latching bits
      q_nxt.state       = prs_pkg::PRS_HW_HOLD;
      q_nxt.cnt         = '0;
      q_nxt.latch_clear = 1'b1;
      // (RULE_09) hw reset never sets the bit
      q_nxt.sw_bit      = 1'b0;
    end
    else if (sw_reset_write && sw_ok && !hw_req)
    begin
      // (RULE_06) write of one starts sw reset; set beats the self-clear
      q_nxt.state        = prs_pkg::PRS_SW_HOLD;
      q_nxt.cnt          = '0;
      q_nxt.sw_bit       = 1'b1;
      q_nxt.regs_default = 1'b0;
      q_nxt.latch_clear  = 1'b1;
    end

    // (RULE_13) control-bit power-down clears only latching bits
    if (power_down_ctrl && !q_r.pd_prev)
      q_nxt.latch_clear = 1'b1;

    in_reset = (q_nxt.state == prs_pkg::PRS_POR_WAIT) || (q_nxt.state == prs_pkg::PRS_POR_HOLD)
               || (q_nxt.state == prs_pkg::PRS_HW_HOLD) || (q_nxt.state == prs_pkg::PRS_SW_HOLD)
               || (q_nxt.state == prs_pkg::PRS_EXIT);
    running  = (q_nxt.state == prs_pkg::PRS_CLK_WAIT) || (q_nxt.state == prs_pkg::PRS_RUN);

    // (RULE_11) pin low or control bit; sw hold excluded
    // (RULE_07) software reset stays powered
    q_nxt.power_down = pin_low || power_down_ctrl
                       || (q_nxt.state == prs_pkg::PRS_POR_WAIT)
                       || (q_nxt.state == prs_pkg::PRS_POR_HOLD)
                       || (q_nxt.state == prs_pkg::PRS_HW_HOLD);
    q_nxt.core_reset   = in_reset;
    q_nxt.mgmt_ready   = running;
    // (RULE_12) MAC low and line tri-stated in power-down or reset
    q_nxt.mac_en       = running && !q_nxt.power_down;
    q_nxt.mac_iso      = !(running && !q_nxt.power_down);
    q_nxt.line_oe      = running && !q_nxt.power_down;
    // (RULE_03) MAC may use data path only after this
    q_nxt.clocks_valid = (q_nxt.state == prs_pkg::PRS_RUN) && !q_nxt.power_down;
    // (RULE_14) drop 100 Mb/s modules at 10 Mb/s
    q_nxt.en_100 = q_nxt.mac_en && !(auto_off_100_in_10 && !speed_is_100);
    // (RULE_15) drop 10 Mb/s modules at 100 Mb/s
    q_nxt.en_10  = q_nxt.mac_en && !(auto_off_10_in_100 && speed_is_100);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      q_r              <= '0;
      q_r.state        <= prs_pkg::PRS_POR_WAIT;
      q_r.addr         <= prs_pkg::ADDR_RST;
      q_r.core_reset   <= 1'b1;
      q_r.power_down   <= 1'b1;
      q_r.mac_iso      <= 1'b1;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign sw_reset_bit       = q_r.sw_bit;
  assign mgmt_address       = q_r.addr;
  assign mgmt_ready         = q_r.mgmt_ready;
  assign regs_to_default    = q_r.regs_default;
  assign latch_status_clear = q_r.latch_clear;
  assign core_reset         = q_r.core_reset;
  assign power_down         = q_r.power_down;
  assign mac_out_enable     = q_r.mac_en;
  assign mac_in_isolate     = q_r.mac_iso;
  assign line_transmit_oe   = q_r.line_oe;
  assign link_clocks_valid  = q_r.clocks_valid;
  assign enable_100_modules = q_r.en_100;
  assign enable_10_modules  = q_r.en_10;

endmodule // prs_seq

// File: core/prs_sync.sv
// two-stage synchroniser for pins entering the clk_sys domain
module prs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // prs_sync
